// file: logic/bsz_sequencer.sv
// Purpose: Split data reads and writes into bus cycles for 32, 16 and 8 bit memory and arbitrate hold.
// Assumes: All pin inputs are asynchronous and pass two flip-flops; request inputs are synchronous.
// Notes: Each bus cycle lasts until the synchronised ready pin is seen, so cycles are slow but safe.
`timescale 1ns/1ps
`default_nettype none

module bsz_sequencer
  import bsz_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic req_valid,
  input wire bsz_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  input wire logic [1:0] bus_width,
  input wire logic bus_ready,
  input wire logic bus_retry,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_hold_request,
  output bsz_bus_t bus
);

  bsz_st_t st_ff;
  bsz_st_t nxt_st;
  logic [1:0] width_s;
  logic [31:0] rdata_s;
  logic [3:0] off_mask;
  logic [3:0] half_mask;
  logic [3:0] cur_be;
  logic [31:0] cur_wdata;
  logic [31:0] rbuf_upd;
  logic cache_fill;
  logic [3:0] own_word;
  logic [3:0] other_word;
  logic [2:0] sel_cnt;

  // Only the second stage of each synchroniser is read below.
  assign width_s = st_ff.width_m[3:2];
  assign rdata_s = st_ff.rdata_m[63:32];

  // A cacheable read ignores byte_sel after its first cycle because it fills the whole doubleword.
  assign cache_fill = !req.write && req.cacheable;
  assign own_word = req.addr[1] ? (BSZ_LOW_WORD << 2) : BSZ_LOW_WORD;
  assign other_word = ~own_word;
  assign sel_cnt = 3'(req.byte_sel[0]) + 3'(req.byte_sel[1]) + 3'(req.byte_sel[2]) + 3'(req.byte_sel[3]);

  always_comb begin
    nxt_st = st_ff;
    off_mask = 4'h1 << st_ff.off;
    // Marks the word that the cycle just finished covered on a 16-bit bus.
    half_mask = st_ff.off[1] ? (BSZ_LOW_WORD << 2) : BSZ_LOW_WORD;
    cur_be = 4'h0;
    cur_wdata = BSZ_DATA_RESET;
    rbuf_upd = st_ff.rbuf;
    // Pins pass two flip-flops before any decision reads them.
    nxt_st.hold_m = {st_ff.hold_m[0], bus_hold_request};
    nxt_st.ready_m = {st_ff.ready_m[0], bus_ready};
    nxt_st.retry_m = {st_ff.retry_m[0], bus_retry};
    nxt_st.width_m = {st_ff.width_m[1:0], bus_width};
    nxt_st.rdata_m = {st_ff.rdata_m[31:0], bus_rdata};
    // The completion flag drops each cycle unless a sequence ends below, so it is a one-cycle pulse.
    nxt_st.rsp_valid = 1'b0;

    // Lanes that the current cycle enables.
    if (st_ff.req.cacheable && !st_ff.req.write && !st_ff.first && st_ff.width != BSZ_WIDTH_32) begin
      cur_be = BSZ_ALL_LANES;
    end else if (st_ff.width == BSZ_WIDTH_8) begin
      cur_be = st_ff.rem;
    end else begin
      cur_be = st_ff.rem;
    end

    // Lane 1 carries lane 3 when the cycle starts in the upper word.
    cur_wdata = {st_ff.req.wdata[31:16],
                 st_ff.off[1] ? st_ff.req.wdata[31:24] : st_ff.req.wdata[15:8],
                 st_ff.req.wdata[8 * st_ff.off +: 8]};

    // Place the returned lanes into the assembled doubleword.
    unique case (st_ff.width)
      BSZ_WIDTH_8: rbuf_upd[8 * st_ff.off +: 8] = rdata_s[7:0];
      BSZ_WIDTH_16: rbuf_upd[16 * st_ff.off[1] +: 16] = rdata_s[15:0];
      default: rbuf_upd = rdata_s;
    endcase

    unique case (st_ff.state)
      BSZ_IDLE: begin
        if (req_valid && st_ff.req_ready) begin
          nxt_st.req = req;
          // The width pin is latched once here, so a change mid-sequence cannot split a cycle.
          nxt_st.width = width_s;
          nxt_st.off = req.addr[1:0];
          nxt_st.first = 1'b1;
          // Cleared at each take, so stale bytes of an earlier sequence never reach rsp_rdata.
          nxt_st.rbuf = BSZ_DATA_RESET;
          nxt_st.state = BSZ_GAP;
          nxt_st.req_ready = 1'b0;
          if (width_s == BSZ_WIDTH_8) begin
            nxt_st.rem = req.byte_sel;
            nxt_st.cnt = cache_fill ? 3'h4 : sel_cnt;
          end else if (width_s == BSZ_WIDTH_16) begin
            // The first cycle enables every selected lane, also those of the other word;
            // only the second cycle is narrowed to the bytes that are still missing, except in a cacheable read, whose second cycle enables all lanes.
            nxt_st.rem = req.byte_sel;
            if (cache_fill || (req.byte_sel & other_word) != 4'h0) begin
              nxt_st.cnt = 3'h2;
            end else begin
              nxt_st.cnt = 3'h1;
            end
          end else begin
            nxt_st.rem = req.byte_sel;
            // A 32-bit read is one cycle even when cacheable; burst refills are not modelled.
            nxt_st.cnt = 3'h1;
          end
        end else if (st_ff.hold_m[1]) begin
          // Outputs float one edge before the acknowledge rises.
          // A request seen in the same cycle wins; the hold is then granted when it ends.
          nxt_st.state = BSZ_HELD;
          nxt_st.req_ready = 1'b0;
          nxt_st.bus.drive_en = 1'b0;
        end else begin
          nxt_st.req_ready = 1'b1;
        end
      end

      // A gap with strobe low separates cycles, so memory sees every cycle, retries too, as new.
      BSZ_GAP: begin
        nxt_st.bus.addr = {st_ff.req.addr[31:2], st_ff.off};
        nxt_st.bus.byte_lane_enable_n = ~cur_be;
        nxt_st.bus.wdata = cur_wdata;
        nxt_st.bus.write = st_ff.req.write;
        nxt_st.bus.strobe = 1'b1;
        nxt_st.state = BSZ_CYCLE;
      end

      BSZ_CYCLE: begin
        if (st_ff.ready_m[1]) begin
          nxt_st.bus.strobe = 1'b0;
          nxt_st.bus.byte_lane_enable_n = BSZ_BE_N_RESET;
          nxt_st.state = BSZ_GAP;
          if (!st_ff.retry_m[1]) begin
            // A retried cycle repeats unchanged and does not lower the count of the same sequence.
            nxt_st.rbuf = rbuf_upd;
            nxt_st.first = 1'b0;
            nxt_st.cnt = st_ff.cnt - 3'h1;
            if (st_ff.width == BSZ_WIDTH_8) begin
              nxt_st.off = st_ff.off + 2'h1;
              nxt_st.rem = st_ff.rem & ~off_mask;
            end else begin
              // The other word starts at its even byte, whatever lane the first cycle began on.
              nxt_st.off = {~st_ff.off[1], 1'b0};
              nxt_st.rem = st_ff.req.byte_sel & ~half_mask;
            end
            if (st_ff.cnt == 3'h1) begin
              nxt_st.state = BSZ_IDLE;
              nxt_st.rsp_valid = 1'b1;
              nxt_st.req_ready = !st_ff.hold_m[1];
            end
          end
        end
      end

      // The acknowledge waits one edge after the outputs float, so a requester never meets a driven bus.
      BSZ_HELD: begin
        if (!st_ff.bus.bus_hold_acknowledge && !st_ff.bus.drive_en) begin
          nxt_st.bus.bus_hold_acknowledge = 1'b1;
        end else if (!st_ff.hold_m[1]) begin
          nxt_st.bus.bus_hold_acknowledge = 1'b0;
          nxt_st.bus.drive_en = 1'b1;
          nxt_st.state = BSZ_IDLE;
        end
      end
    endcase
  end

  // Every pin is spelt out in reset, so the idle bus level does not hang on the struct layout.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.state <= BSZ_IDLE;
      st_ff.bus.byte_lane_enable_n <= BSZ_BE_N_RESET;
      st_ff.bus.addr <= BSZ_ADDR_RESET;
      st_ff.bus.drive_en <= 1'b1;
      st_ff.cnt <= BSZ_CNT_RESET;
      st_ff.bus.wdata <= BSZ_DATA_RESET;
      st_ff.bus.strobe <= 1'b0;
      st_ff.bus.write <= 1'b0;
      st_ff.bus.bus_hold_acknowledge <= 1'b0;
      st_ff.req_ready <= 1'b0;
      st_ff.rsp_valid <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a field of the state register, so none has a combinational path.
  assign req_ready = st_ff.req_ready;
  assign rsp_valid = st_ff.rsp_valid;
  assign rsp_rdata = st_ff.rbuf;
  assign bus = st_ff.bus;

endmodule : bsz_sequencer
`default_nettype wire

// file: include/bsz_pkg.sv
// Purpose: Shared types and constants for the bus sizing access sequencer.
// Assumes: One 100 MHz bus clock; sequences never cross a doubleword.
// Notes: The bus width code is read from pins once per access sequence.
package bsz_pkg;

  localparam int unsigned BSZ_CLK_MHZ = 100;
  localparam logic [1:0] BSZ_WIDTH_32 = 2'h0;
  localparam logic [1:0] BSZ_WIDTH_16 = 2'h1;
  localparam logic [1:0] BSZ_WIDTH_8 = 2'h2;
  localparam logic [3:0] BSZ_ALL_LANES = 4'hF;
  localparam logic [3:0] BSZ_LOW_WORD = 4'h3;
  localparam logic [3:0] BSZ_BE_N_RESET = 4'hF;
  localparam logic [31:0] BSZ_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] BSZ_DATA_RESET = 32'h0000_0000;
  localparam logic [2:0] BSZ_CNT_RESET = 3'h0;

  typedef enum logic [1:0] {
    BSZ_IDLE,
    BSZ_CYCLE,
    BSZ_GAP,
    BSZ_HELD
  } bsz_state_t;

  // Access request from the execution side.
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] byte_sel;
    logic write;
    logic cacheable;
    logic [31:0] wdata;
  } bsz_req_t;

  // Pins that face the external bus, all registered.
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] byte_lane_enable_n;
    logic [31:0] wdata;
    logic write;
    logic strobe;
    logic drive_en;
    logic bus_hold_acknowledge;
  } bsz_bus_t;

  typedef struct packed {
    bsz_state_t state;
    logic [1:0] hold_m;
    logic [1:0] ready_m;
    logic [1:0] retry_m;
    logic [3:0] width_m;
    logic [63:0] rdata_m;
    bsz_req_t req;
    logic [1:0] width;
    logic [3:0] rem;
    logic [1:0] off;
    logic [2:0] cnt;
    logic first;
    logic [31:0] rbuf;
    logic req_ready;
    logic rsp_valid;
    bsz_bus_t bus;
  } bsz_st_t;

endpackage : bsz_pkg

// file: testbench/bsz_sva.sv
// Purpose: Checker for the bus sizing sequencer.
// Assumes: Top module ports only.
// Notes: Bind at foot.
`timescale 1ns/1ps
`default_nettype none
module bsz_sva
  import bsz_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic bus_hold_request,
  input wire bsz_bus_t bus
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  lane_at_addr_a: assert property (bus.strobe |-> !bus.byte_lane_enable_n[bus.addr[1:0]])
    else $error("addressed lane off");
  idle_lanes_a: assert property (!bus.strobe |-> bus.byte_lane_enable_n == BSZ_BE_N_RESET)
    else $error("lane on outside cycle");
  dup_low_a: assert property (bus.strobe && bus.write |->
    bus.wdata[7:0] == bus.wdata[{bus.addr[1:0], 3'h0} +: 8]) else $error("lane 0 copy");
  dup_mid_a: assert property (bus.strobe && bus.write && bus.addr[1] |->
    bus.wdata[15:8] == bus.wdata[31:24]) else $error("lane 1 copy");
  ack_float_a: assert property (bus.bus_hold_acknowledge |-> !bus.drive_en && !bus.strobe)
    else $error("driving while granted");
  ack_after_a: assert property ($rose(bus.bus_hold_acknowledge) |-> $past(bus.drive_en) == 1'b0)
    else $error("grant before float");
  bus_return_a: assert property ($fell(bus_hold_request) && bus.bus_hold_acknowledge |->
    ##[1:5] (!bus.bus_hold_acknowledge && bus.drive_en)) else $error("bus not returned");
  idle_grant_a: assert property ($rose(bus_hold_request) && req_ready ##0 !req_valid [*4] |->
    ##[0:4] bus.bus_hold_acknowledge) else $error("idle grant late");
  seq_hold_a: assert property (bus.strobe |-> !bus.bus_hold_acknowledge until rsp_valid)
    else $error("grant inside sequence");
  seq_end_a: assert property (bus.strobe |-> ##[0:200] rsp_valid)
    else $error("sequence never ends");
endmodule : bsz_sva
bind bsz_sequencer bsz_sva u_sva (.clock(clock), .reset(reset), .req_valid(req_valid),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .bus_hold_request(bus_hold_request), .bus(bus));
`default_nettype wire

// file: testbench/bsz_mem_model.sv
// Purpose: Memory behind the sized bus.
// Assumes: One bus cycle at a time.
// Notes: Undriven lanes carry inverted data, never the last value.
`timescale 1ns/1ps
`default_nettype none
module bsz_mem_model
  import bsz_pkg::*;
(
  input wire logic clock,
  input wire bsz_bus_t bus,
  input wire logic [1:0] width,
  input wire logic retry_once,
  output logic bus_ready,
  output logic bus_retry,
  output logic [31:0] bus_rdata
);
  localparam logic [31:0] MEM = 32'h4433_2211;
  logic [31:0] la [8];
  logic [3:0] lb [8];
  logic [31:0] lw [8];
  logic lwr [8];
  logic [31:0] d;
  logic rt;
  logic rdone = 1'b0;
  int n_cyc = 0;
  initial begin
    bus_ready = 1'b0;
    bus_retry = 1'b0;
    bus_rdata = ~MEM;
    forever begin
      @(posedge clock);
      if (!retry_once) rdone = 1'b0;
      if (bus.strobe) begin
        repeat (n_cyc % 3) @(posedge clock);
        rt = retry_once && !rdone;
        rdone = rdone | rt;
        d = MEM >> {bus.addr[1:0], 3'h0};
        if (width == BSZ_WIDTH_16) d = MEM >> {bus.addr[1], 4'h0};
        bus_rdata <= (width == BSZ_WIDTH_8) ? {{3{~d[7:0]}}, d[7:0]} :
          (width == BSZ_WIDTH_16) ? {~d[15:0], d[15:0]} : MEM;
        bus_retry <= rt;
        bus_ready <= 1'b1;
        @(posedge clock);
        bus_ready <= 1'b0;
        bus_retry <= 1'b0;
        if (!rt) begin
          la[n_cyc] = bus.addr;
          lb[n_cyc] = bus.byte_lane_enable_n;
          lw[n_cyc] = bus.wdata;
          lwr[n_cyc] = bus.write;
          n_cyc++;
        end
        while (bus.strobe) @(posedge clock);
        bus_rdata <= ~bus_rdata;
      end
    end
  end
endmodule : bsz_mem_model
`default_nettype wire

// file: testbench/bus_sizing_access_sequencer_tb_top.sv
// Purpose: Bench for the bus sizing sequencer.
// Assumes: Memory model answers every cycle.
// Notes: Width pin flips after each take on purpose.
`timescale 1ns/1ps
`default_nettype none
module bus_sizing_access_sequencer_tb_top;
  import bsz_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic bus_hold_request = 1'b0;
  logic rto = 1'b0;
  logic [1:0] bus_width = BSZ_WIDTH_32;
  logic [1:0] mw = BSZ_WIDTH_32;
  bsz_req_t req = '0;
  logic req_ready, rsp_valid, bus_ready, bus_retry;
  logic [31:0] rsp_rdata, bus_rdata;
  bsz_bus_t bus;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  bsz_sequencer u_dut (.clock(clock), .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_width(bus_width), .bus_ready(bus_ready),
    .bus_retry(bus_retry), .bus_rdata(bus_rdata), .bus_hold_request(bus_hold_request), .bus(bus));
  bsz_mem_model u_mem (.clock(clock), .bus(bus), .width(mw), .retry_once(rto), .bus_ready(bus_ready),
    .bus_retry(bus_retry), .bus_rdata(bus_rdata));
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize;
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic go(input logic [31:0] a, input logic [3:0] s, input logic w, c, input logic [1:0] bw,
      input logic [31:0] d);
    int k;
    @(negedge clock);
    u_mem.n_cyc = 0;
    bus_width = bw;
    mw = bw;
    req = '{a, s, w, c, d};
    repeat (3) @(negedge clock);
    req_valid = 1'b1;
    for (k = 0; k < 50 && req_ready !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
    req_valid = 1'b0;
    chk(req_ready, 32'h0);
    bus_width = ~bw;
    for (k = 0; k < 200 && rsp_valid !== 1'b1; k++) @(negedge clock);
    chk(rsp_valid, 32'h1);
  endtask : go
  task automatic ack(input logic v);
    int k;
    for (k = 0; k < 20 && bus.bus_hold_acknowledge !== v; k++) @(negedge clock);
    chk(bus.bus_hold_acknowledge, v);
  endtask : ack
  task automatic t_w32;
    go(32'h6, 4'h4, 1'b1, 1'b0, BSZ_WIDTH_32, 32'h00CC_0000);
    chk({u_mem.n_cyc[3:0], u_mem.lb[0], u_mem.la[0][7:0], u_mem.lw[0][7:0]}, 32'h1B06CC);
    chk(u_mem.lwr[0], 32'h1);
    go(32'h7, 4'h8, 1'b1, 1'b0, BSZ_WIDTH_8, 32'hEE00_0000);
    chk({u_mem.lb[0], u_mem.lw[0][15:0]}, 32'h7EEEE);
  endtask : t_w32
  task automatic t_w16;
    rto = 1'b1;
    fork
      go(32'h5, 4'h6, 1'b1, 1'b0, BSZ_WIDTH_16, 32'h00BB_AA00);
      begin
        repeat (6) @(negedge clock);
        bus_hold_request = 1'b1;
      end
    join
    rto = 1'b0;
    chk({u_mem.n_cyc[3:0], u_mem.la[0][3:0], u_mem.lb[0], u_mem.lw[0][7:0]}, 32'h259AA);
    chk({u_mem.la[1][3:0], u_mem.lb[1], u_mem.lw[1][7:0]}, 32'h6BBB);
    ack(1'b1);
    bus_hold_request = 1'b0;
    ack(1'b0);
  endtask : t_w16
  task automatic t_r16;
    go(32'h5, 4'h2, 1'b0, 1'b1, BSZ_WIDTH_16, 32'h0);
    chk({u_mem.n_cyc[3:0], u_mem.la[1][3:0], u_mem.lb[1]}, 32'h260);
    chk(rsp_rdata, 32'h4433_2211);
    go(32'h5, 4'h2, 1'b0, 1'b0, BSZ_WIDTH_16, 32'h0);
    chk({u_mem.n_cyc[3:0], u_mem.lb[0], rsp_rdata[15:8]}, 32'h1D22);
    go(32'h1, 4'hE, 1'b0, 1'b0, BSZ_WIDTH_16, 32'h0);
    chk({u_mem.n_cyc[3:0], u_mem.la[1][3:0], u_mem.lb[1]}, 32'h223);
    go(32'h6, 4'hC, 1'b0, 1'b1, BSZ_WIDTH_32, 32'h0);
    chk({u_mem.n_cyc[3:0], u_mem.lb[0], rsp_rdata[23:0]}, 32'h1333_2211);
  endtask : t_r16
  task automatic t_r8;
    logic [7:0] e [4] = '{8'h59, 8'h60, 8'h70, 8'h40};
    go(32'h5, 4'h6, 1'b0, 1'b1, BSZ_WIDTH_8, 32'h0);
    chk({u_mem.n_cyc[3:0], rsp_rdata[27:0]}, 32'h4433_2211);
    chk(u_mem.lwr[0], 32'h0);
    for (int i = 0; i < 4; i++) chk({u_mem.la[i][3:0], u_mem.lb[i]}, e[i]);
    go(32'h5, 4'h6, 1'b0, 1'b0, BSZ_WIDTH_8, 32'h0);
    chk({u_mem.n_cyc[3:0], u_mem.la[1][3:0], u_mem.lb[1]}, 32'h26B);
  endtask : t_r8
  task automatic t_w8;
    logic [15:0] e [4] = '{16'h40AA, 16'h51BB, 16'h63CC, 16'h77DD};
    go(32'h4, 4'hF, 1'b1, 1'b0, BSZ_WIDTH_8, 32'hDDCC_BBAA);
    chk(u_mem.n_cyc, 32'h4);
    for (int i = 0; i < 4; i++) chk({u_mem.la[i][3:0], u_mem.lb[i], u_mem.lw[i][7:0]}, e[i]);
  endtask : t_w8
  task automatic t_idle;
    @(negedge clock);
    bus_hold_request = 1'b1;
    ack(1'b1);
    chk(bus.drive_en, 32'h0);
    bus_hold_request = 1'b0;
    ack(1'b0);
  endtask : t_idle
  initial begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    t_w32();
    t_w16();
    t_r16();
    t_r8();
    t_w8();
    t_idle();
    summarize();
  end
endmodule : bus_sizing_access_sequencer_tb_top
`default_nettype wire
